// [rtl/msma_pkg.sv]
// package: constants, types and helpers of the min search and running mean unit
package msma_pkg;
    // word memory and area layout
    localparam int unsigned MEM_DEPTH = 1024;
    localparam int unsigned AREA_BIT  = 9;
    localparam logic        DATA_AREA = 1'b0; // data_memory_area low, io_relay_area high
    // register byte offsets
    localparam logic [7:0]  OFF_CMD   = 8'h00;
    localparam logic [7:0]  OFF_CWORD = 8'h04;
    localparam logic [7:0]  OFF_OPA   = 8'h08;
    localparam logic [7:0]  OFF_DEST  = 8'h0C;
    localparam logic [7:0]  OFF_STAT  = 8'h10;
    localparam logic [7:0]  OFF_MADDR = 8'h14;
    localparam logic [7:0]  OFF_MDATA = 8'h18;
    // field positions
    localparam int unsigned CMD_RUNG  = 0;
    localparam int unsigned CMD_OP    = 1;
    localparam int unsigned C_LOC     = 14;
    localparam int unsigned C_SIGN    = 15;
    localparam int unsigned IND_BIT   = 15;
    // limits and small constants
    localparam logic [13:0] AVG_N_MAX = 14'h0040; // 64 cycles
    localparam logic [13:0] N_ZERO    = 14'h0000;
    localparam logic [9:0]  ONE10     = 10'h001;
    localparam logic [9:0]  TWO10     = 10'h002;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE, ST_MIN_SCAN, ST_MIN_DEST, ST_MIN_LOC,
        ST_AVG_PTR, ST_AVG_STORE, ST_AVG_SUM, ST_AVG_OUT, ST_AVG_STAT
    } msma_state_e;

    typedef struct packed {
        logic        awready, wready, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        aw_got, w_got;
        logic [7:0]  awaddr;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        msma_state_e st;
        logic        op;
        logic [15:0] cword, opa, best_val;
        logic [9:0]  dest, maddr, base, idx, cnt, best_addr;
        logic [6:0]  ptr;
        logic        ind;
        logic [22:0] sum;
        logic        fault, zero, neg;
    } msma_s;

    // true when the low n nibbles are decimal digits
    function automatic logic bcd_ok(input logic [15:0] v, input int n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (i < n && v[4*i +: 4] > 4'h9) ok = 1'b0;
        end
        return ok;
    endfunction : bcd_ok

    function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
        return 14'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
    endfunction : bcd_to_bin

    function automatic logic [15:0] bin_to_bcd(input logic [9:0] b);
        return {4'(b / 1000), 4'((b / 100) % 10), 4'((b / 10) % 10), 4'(b % 10)};
    endfunction : bin_to_bcd

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] n,
                                            input logic [1:0] s);
        return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction : merge16
endpackage : msma_pkg

// [rtl/msma_top.sv]
// module: min search and running mean unit with AXI4-Lite registers and word memory

// How it works
// RQ1 - rung false: min search changes nothing
// RQ2 - scan N words, write minimum to destination
// RQ3 - control bit 14 writes location after destination
// RQ4 - data area range reports absolute address
// RQ5 - other areas report offset from start
// RQ6 - ties report lowest address
// RQ7 - count is three BCD digits, 001..999
// RQ8 - control bit 15 picks signed compare
// RQ9 - fault on bad count or area crossing
// RQ10 - zero flag when minimum is zero
// RQ11 - negative flag from destination bit 15
// RQ12 - rung false: mean leaves everything unchanged
// RQ13 - cycle count BCD 0001..0064 only
// RQ14 - first N-1 runs copy source, indicator clear
// RQ15 - pointer in low status digits, increments
// RQ16 - Nth run averages, sets indicator, zeroes pointer
// RQ17 - then overwrite at pointer, wrap after N-1
// RQ18 - pointer 0 selects word two past output
// RQ19 - mean is 16-bit, rounded to nearest
// RQ20 - fault on any invalid mean operand
// RQ21 - program keeps mean words in one area
// RQ22 - signed compare treats words as two's complement
module msma_top
    import msma_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // write address channel
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // write data channel
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // write response channel
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // read address channel
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // read data channel
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    msma_s       r;
    msma_s       nx;
    logic [15:0] mem [MEM_DEPTH];
    logic        mem_we;
    logic [9:0]  mem_wa;
    logic [15:0] mem_wd;
    logic [9:0]  rd_addr;
    logic [15:0] rd_word;
    logic [15:0] rd_mwin;
    logic        go;
    logic        cmd_wr;
    logic [13:0] n;
    logic [13:0] last;
    logic [22:0] total;
    logic        take;
    logic        wrap;

    // memory read ports: engine and software window
    assign rd_word = mem[rd_addr];
    assign rd_mwin = mem[r.maddr];

    // outputs straight from state
    assign S_AXI_AWREADY = r.awready;
    assign S_AXI_WREADY  = r.wready;
    assign S_AXI_BRESP   = r.bresp;
    assign S_AXI_BVALID  = r.bvalid;
    assign S_AXI_ARREADY = r.arready;
    assign S_AXI_RDATA   = r.rdata;
    assign S_AXI_RRESP   = r.rresp;
    assign S_AXI_RVALID  = r.rvalid;

    // next state: bus slave then execution engine
    always_comb begin
        nx      = r;
        mem_we  = 1'b0;
        mem_wa  = r.maddr;
        mem_wd  = r.wdata;
        rd_addr = r.base + r.idx;
        go      = 1'b0;
        cmd_wr  = 1'b0;
        n       = N_ZERO;
        last    = N_ZERO;
        total   = 23'h00_0000;
        take    = 1'b0;
        wrap    = 1'b0;
        // address and data captured in either order
        if (S_AXI_AWVALID && r.awready) begin
            nx.awaddr  = S_AXI_AWADDR;
            nx.aw_got  = 1'b1;
            nx.awready = 1'b0;
        end
        if (S_AXI_WVALID && r.wready) begin
            nx.wdata  = S_AXI_WDATA[15:0];
            nx.wstrb  = S_AXI_WSTRB[1:0];
            nx.w_got  = 1'b1;
            nx.wready = 1'b0;
        end
        // register write once both halves are held
        if (r.aw_got && r.w_got && !r.bvalid) begin
            nx.aw_got = 1'b0;
            nx.w_got  = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp  = RESP_OKAY;
            if (r.st != ST_IDLE) begin
                nx.bresp = RESP_SLV; // busy: nothing is changed
            end else begin
                case (r.awaddr)
                    OFF_CMD: begin
                        cmd_wr = 1'b1;
                        go     = r.wdata[CMD_RUNG]; // RQ1 RQ12
                        nx.op  = r.wdata[CMD_OP];
                    end
                    OFF_CWORD: nx.cword = merge16(r.cword, r.wdata, r.wstrb);
                    OFF_OPA:   nx.opa = merge16(r.opa, r.wdata, r.wstrb);
                    OFF_DEST:  nx.dest = 10'(merge16({6'h00, r.dest}, r.wdata, r.wstrb));
                    OFF_MADDR: nx.maddr = 10'(merge16({6'h00, r.maddr}, r.wdata, r.wstrb));
                    OFF_STAT:  nx.bresp = RESP_OKAY; // read only
                    OFF_MDATA: begin
                        mem_we = 1'b1;
                        mem_wd = merge16(rd_mwin, r.wdata, r.wstrb);
                    end
                    default:   nx.bresp = RESP_SLV;
                endcase
            end
        end
        if (r.bvalid && S_AXI_BREADY) begin
            nx.bvalid  = 1'b0;
            nx.awready = 1'b1;
            nx.wready  = 1'b1;
        end
        // register read, answered one edge after the address
        if (S_AXI_ARVALID && r.arready) begin
            nx.arready = 1'b0;
            nx.rvalid  = 1'b1;
            nx.rresp   = RESP_OKAY;
            nx.rdata   = 32'h0000_0000;
            case (S_AXI_ARADDR)
                OFF_CMD:   nx.rdata = 32'({r.op, 1'b0});
                OFF_CWORD: nx.rdata = 32'(r.cword);
                OFF_OPA:   nx.rdata = 32'(r.opa);
                OFF_DEST:  nx.rdata = 32'(r.dest);
                OFF_STAT:  nx.rdata = 32'({r.neg, r.zero, r.fault, r.st != ST_IDLE});
                OFF_MADDR: nx.rdata = 32'(r.maddr);
                OFF_MDATA: nx.rdata = 32'(rd_mwin);
                default:   nx.rresp = RESP_SLV;
            endcase
        end
        if (r.rvalid && S_AXI_RREADY) begin
            nx.rvalid  = 1'b0;
            nx.arready = 1'b1;
        end
        // execution engine, one memory word per cycle
        case (r.st)
            ST_IDLE: begin
                // decode the op being written now, not the one held from before
                if (go && !nx.op) begin
                    n    = bcd_to_bin({4'h0, r.cword[11:0]}); // RQ7
                    last = 14'(r.opa[9:0]) + n - 14'(ONE10);
                    if (!bcd_ok(r.cword, 3) || n == N_ZERO || last >= 14'(MEM_DEPTH) ||
                        last[AREA_BIT] != r.opa[AREA_BIT]) begin
                        nx.fault = 1'b1; // RQ9
                    end else begin
                        nx.st   = ST_MIN_SCAN;
                        nx.base = r.opa[9:0];
                        nx.cnt  = n[9:0];
                        nx.idx  = 10'h000;
                    end
                end else if (go) begin
                    n    = bcd_to_bin(r.cword);
                    last = 14'(r.dest) + n + 14'(ONE10);
                    if (!bcd_ok(r.cword, 4) || n == N_ZERO || n > AVG_N_MAX || // RQ13
                        last >= 14'(MEM_DEPTH) || last[AREA_BIT] != r.dest[AREA_BIT]) begin
                        nx.fault = 1'b1; // RQ20
                    end else begin
                        nx.st  = ST_AVG_PTR;
                        nx.cnt = n[9:0];
                    end
                end
            end
            ST_MIN_SCAN: begin
                if (r.cword[C_SIGN]) begin
                    take = $signed(rd_word) < $signed(r.best_val); // RQ8 RQ22
                end else begin
                    take = rd_word < r.best_val;
                end
                if (r.idx == 10'h000 || take) begin // strict: first of equals kept RQ6
                    nx.best_val  = rd_word;
                    nx.best_addr = r.idx;
                end
                nx.idx = r.idx + ONE10;
                if (r.idx == r.cnt - ONE10) nx.st = ST_MIN_DEST; // RQ2
            end
            ST_MIN_DEST: begin
                mem_we   = 1'b1;
                mem_wa   = r.dest;
                mem_wd   = r.best_val; // RQ2
                nx.zero  = r.best_val == WORD_ZERO; // RQ10
                nx.neg   = r.best_val[15]; // RQ11
                nx.fault = 1'b0;
                nx.st    = r.cword[C_LOC] ? ST_MIN_LOC : ST_IDLE; // RQ3
            end
            ST_MIN_LOC: begin
                mem_we = 1'b1;
                mem_wa = r.dest + ONE10; // RQ3
                if (r.base[AREA_BIT] == DATA_AREA) begin
                    mem_wd = bin_to_bcd(r.base + r.best_addr); // RQ4
                end else begin
                    mem_wd = bin_to_bcd(r.best_addr); // RQ5
                end
                nx.st = ST_IDLE;
            end
            ST_AVG_PTR: begin
                rd_addr = r.dest + ONE10;
                n       = bcd_to_bin({8'h00, rd_word[7:0]}); // RQ15
                nx.ptr  = n[6:0];
                nx.ind  = rd_word[IND_BIT];
                if (!bcd_ok(rd_word, 2) || n >= 14'(r.cnt)) begin
                    nx.fault = 1'b1; // RQ20
                    nx.st    = ST_IDLE;
                end else begin
                    nx.st = ST_AVG_STORE;
                end
            end
            ST_AVG_STORE: begin
                mem_we  = 1'b1;
                mem_wa  = r.dest + TWO10 + 10'(r.ptr); // RQ18 RQ17
                mem_wd  = r.opa;
                nx.idx  = 10'h000;
                nx.sum  = 23'h00_0000;
                nx.base = r.dest + TWO10;
                if (!r.ind && 10'(r.ptr) != r.cnt - ONE10) begin
                    nx.best_val = r.opa; // RQ14
                    nx.st       = ST_AVG_OUT;
                end else begin
                    nx.st = ST_AVG_SUM; // RQ16
                end
            end
            // add the n history words, one per cycle
            ST_AVG_SUM: begin
                total  = r.sum + 23'(rd_word);
                nx.sum = total;
                nx.idx = r.idx + ONE10;
                if (r.idx == r.cnt - ONE10) begin
                    nx.best_val = 16'((total + 23'(r.cnt >> 1)) / 23'(r.cnt)); // RQ19
                    nx.st       = ST_AVG_OUT;
                end
            end
            ST_AVG_OUT: begin
                mem_we = 1'b1;
                mem_wa = r.dest;
                mem_wd = r.best_val; // RQ14 RQ16
                nx.st  = ST_AVG_STAT;
            end
            ST_AVG_STAT: begin
                wrap     = 10'(r.ptr) == r.cnt - ONE10;
                nx.ptr   = wrap ? 7'h00 : r.ptr + 7'h01; // RQ15 RQ17
                nx.ind   = r.ind | wrap; // RQ16
                mem_we   = 1'b1;
                mem_wa   = r.dest + ONE10;
                mem_wd   = {nx.ind, 7'h00, 8'(bin_to_bcd(10'(nx.ptr)))};
                nx.fault = 1'b0;
                nx.st    = ST_IDLE;
            end
            default: nx.st = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            r         <= '0;
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
            r.st      <= ST_IDLE;
        end else begin
            r <= nx;
        end
    end

    // operand memory, single write port
    always_ff @(posedge MCLK) begin
        if (mem_we) mem[mem_wa] <= mem_wd;
    end

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_min_dest;
        r.st == ST_MIN_DEST && r.cword[C_LOC];
    endsequence
    sequence s_loc_then_idle;
        r.st == ST_MIN_LOC ##1 r.st == ST_IDLE;
    endsequence

    a_rung_low_idle: assert property (cmd_wr && !go |=> r.st == ST_IDLE && // RQ1 RQ12
        $stable({r.fault, r.zero, r.neg}))
        else $error("rung low started or changed flags");
    a_min_bad_count: assert property (go && !nx.op && !bcd_ok(r.cword, 3) // RQ9
        |=> r.fault && r.st == ST_IDLE)
        else $error("bad count did not fault");
    a_min_flag_set: assert property (r.st == ST_MIN_DEST |=> // RQ10 RQ11
        r.zero == (r.best_val == WORD_ZERO) && r.neg == r.best_val[15] && !r.fault)
        else $error("minimum flags wrong");
    a_min_tie_low: assert property (r.st == ST_MIN_SCAN && r.idx != 10'h000 && // RQ6
        rd_word == r.best_val |=> $stable(r.best_addr))
        else $error("tie moved the location");
    a_min_loc_step: assert property (s_min_dest |=> s_loc_then_idle) // RQ3
        else $error("location word not written");
    a_avg_bad_count: assert property (go && nx.op && bcd_to_bin(r.cword) > AVG_N_MAX // RQ13
        |=> r.fault && r.st == ST_IDLE)
        else $error("bad cycle count did not fault");
    a_avg_copy_out: assert property (r.st == ST_AVG_STORE && !r.ind && // RQ14
        10'(r.ptr) != r.cnt - ONE10 |=> r.st == ST_AVG_OUT && mem_wd == r.opa)
        else $error("copy phase output wrong");
    a_avg_ptr_wrap: assert property (r.st == ST_AVG_STAT |-> // RQ17
        14'(bcd_to_bin({8'h00, mem_wd[7:0]})) < 14'(r.cnt))
        else $error("pointer beyond count");
    a_avg_ind_set: assert property (r.st == ST_AVG_STAT && 10'(r.ptr) == r.cnt - ONE10 // RQ16
        |-> mem_wd[IND_BIT] && mem_wd[7:0] == 8'h00 ##1 r.ind && r.ptr == 7'h00)
        else $error("indicator or pointer reset wrong");
    a_min_area_cross: assert property (go && !nx.op && last[AREA_BIT] != r.opa[AREA_BIT] // RQ9
        |=> r.fault && r.st == ST_IDLE)
        else $error("area crossing did not fault");
    a_mean_ptr_step: assert property (r.st == ST_AVG_STAT && 10'(r.ptr) != r.cnt - ONE10 // RQ15
        |=> r.ptr == $past(r.ptr) + 7'h01)
        else $error("pointer did not step");
endmodule : msma_top

// [tb/msma_prog_model.sv]
// program-side model that issues register bus requests to the unit
module msma_prog_model (
    // clock
    input  wire logic        clk,
    // write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    // one read: data and response taken at the edge that shows rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : msma_prog_model

// [tb/test_min_search_moving_average.sv]
// self-checking bench of the min search and running mean unit
module test_min_search_moving_average
    import msma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        rst = 1'b1;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cycles    = 0;

    // unit under test
    msma_top u_dut (
        .MCLK(mclk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    // program side issuing the bus requests
    msma_prog_model u_prog (
        .clk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // hang guard, far above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    // register and memory window helpers
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        u_prog.wr(a, d, r);
    endtask : put

    task automatic get(input logic [7:0] a, output logic [15:0] d);
        logic [1:0]  r;
        logic [31:0] x;
        u_prog.rd(a, x, r);
        d = x[15:0];
    endtask : get

    task automatic mset(input logic [9:0] a, input logic [15:0] d);
        put(OFF_MADDR, {6'h00, a});
        put(OFF_MDATA, d);
    endtask : mset

    task automatic mget(input logic [9:0] a, output logic [15:0] d);
        put(OFF_MADDR, {6'h00, a});
        get(OFF_MDATA, d);
    endtask : mget

    // load operands and pulse the rung condition
    task automatic start(input logic op, input logic rung, input logic [15:0] c,
                         input logic [15:0] a, input logic [9:0] dst);
        put(OFF_CWORD, c);
        put(OFF_OPA, a);
        put(OFF_DEST, {6'h00, dst});
        put(OFF_CMD, {14'h0000, op, rung});
    endtask : start

    // poll busy under a bound, return the final status
    task automatic run(input logic op, input logic rung, input logic [15:0] c,
                       input logic [15:0] a, input logic [9:0] dst, output logic [15:0] st);
        start(op, rung, c, a, dst);
        for (int i = 0; i < 400; i++) begin
            get(OFF_STAT, st);
            if (st[0] === 1'b0) break;
        end
    endtask : run

    // reset state and an unmapped address
    task automatic t_bus();
        logic [31:0] x;
        logic [1:0]  r;
        logic [15:0] v;
        u_prog.wr(OFF_STAT, 16'h000f, r);
        chk_resp("stat_write", RESP_OKAY, r);
        get(OFF_STAT, v);
        chk_word("stat_reset", 16'h0000, v);
        u_prog.rd(8'h40, x, r);
        chk_resp("unmapped_resp", RESP_SLV, r);
        chk_word("unmapped_data", 16'h0000, x[15:0]);
    endtask : t_bus

    // unsigned search with location in the data area and a tie
    task automatic t_min_loc();
        logic [15:0] v;
        mset(10'h010, 16'h0005);
        mset(10'h011, 16'h0003);
        mset(10'h012, 16'h0009);
        mset(10'h013, 16'h0003);
        run(1'b0, 1'b1, 16'h4004, 16'h0010, 10'h100, v);
        chk_word("stat", 16'h0000, v);
        mget(10'h100, v);
        chk_word("min", 16'h0003, v);
        mget(10'h101, v);
        chk_word("loc", 16'h0017, v);
    endtask : t_min_loc

    // signed against unsigned in the other area
    task automatic t_min_sign();
        logic [15:0] v;
        mset(10'h210, 16'h0005);
        mset(10'h211, 16'h8000);
        mset(10'h212, 16'h7fff);
        mset(10'h131, 16'hbeef);
        run(1'b0, 1'b1, 16'hc003, 16'h0210, 10'h120, v);
        chk_word("stat", 16'h0008, v);
        mget(10'h120, v);
        chk_word("min", 16'h8000, v);
        mget(10'h121, v);
        chk_word("loc", 16'h0001, v);
        run(1'b0, 1'b1, 16'h0003, 16'h0210, 10'h130, v);
        mget(10'h130, v);
        chk_word("min", 16'h0005, v);
        mget(10'h131, v);
        chk_word("loc", 16'hbeef, v);
    endtask : t_min_sign

    // zero result, then a rung that stays false
    task automatic t_zero();
        logic [15:0] v;
        mset(10'h020, 16'h0007);
        mset(10'h021, 16'h0000);
        run(1'b0, 1'b1, 16'h4002, 16'h0020, 10'h140, v);
        chk_word("stat", 16'h0004, v);
        mget(10'h141, v);
        chk_word("loc", 16'h0033, v);
        mset(10'h150, 16'h1111);
        run(1'b0, 1'b0, 16'h0002, 16'h0020, 10'h150, v);
        chk_word("stat", 16'h0004, v);
        mget(10'h150, v);
        chk_word("dest", 16'h1111, v);
    endtask : t_zero

    // bad counts and an area crossing leave the destination alone
    task automatic t_fault();
        logic [15:0] v;
        mset(10'h160, 16'h2222);
        run(1'b0, 1'b1, 16'h000a, 16'h0010, 10'h160, v);
        chk_word("stat", 16'h0006, v);
        run(1'b0, 1'b1, 16'h0003, 16'h01fe, 10'h160, v);
        chk_word("stat", 16'h0006, v);
        run(1'b0, 1'b1, 16'h0000, 16'h0010, 10'h160, v);
        chk_word("stat", 16'h0006, v);
        mget(10'h160, v);
        chk_word("dest", 16'h2222, v);
    endtask : t_fault

    // running mean over three cycles, then refusals and the top count
    task automatic t_mean();
        logic [15:0] v;
        logic [1:0]  r;
        logic [15:0] src [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0006};
        logic [15:0] running_mean_op [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0002, 16'h0004};
        logic [15:0] ptr [5] = '{16'h0001, 16'h0002, 16'h8000, 16'h8001, 16'h8002};
        mset(10'h181, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            run(1'b1, 1'b1, 16'h0003, src[i], 10'h180, v);
            mget(10'h180, v);
            chk_word("mean", running_mean_op[i], v);
            mget(10'h181, v);
            chk_word("ptr", ptr[i], v);
        end
        mget(10'h182, v);
        chk_word("hist0", 16'h0003, v);
        mget(10'h183, v);
        chk_word("hist1", 16'h0006, v);
        run(1'b1, 1'b0, 16'h0003, 16'h0099, 10'h180, v);
        mget(10'h181, v);
        chk_word("ptr_idle", 16'h8002, v);
        run(1'b1, 1'b1, 16'h0065, 16'h0009, 10'h180, v);
        chk_word("stat", 16'h0006, v);
        mget(10'h180, v);
        chk_word("mean_kept", 16'h0004, v);
        mset(10'h191, 16'h0000);
        start(1'b1, 1'b1, 16'h0064, 16'h0077, 10'h190);
        u_prog.wr(OFF_DEST, 16'h0055, r);
        chk_resp("busy_write", RESP_SLV, r);
        get(OFF_DEST, v);
        chk_word("dest_kept", 16'h0190, v);
        run(1'b0, 1'b0, 16'h0064, 16'h0077, 10'h190, v);
        mget(10'h190, v);
        chk_word("first_copy", 16'h0077, v);
    endtask : t_mean

    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_bus();
        t_min_loc();
        t_min_sign();
        t_zero();
        t_fault();
        t_mean();
        stop_test();
    end
endmodule : test_min_search_moving_average
